// [verilog/move_defines.svh]
// Purpose: Reset values, window addresses and field positions for the literal and indirect move logic.
// Assumes: Included by bare name from every file that needs one of these values.
// Notes: Definitions only; no process or assignment lives here.
`ifndef MOVE_DEFINES_SVH
`define MOVE_DEFINES_SVH

// Reset values of the architectural registers kept by this block.
`define ACC_RESET 8'h00
`define PAGE_RESET 7'h00
`define PTR_RESET 16'h0000

// File addresses of the two indirect window registers.
`define WINDOW0_ADDR 7'h00
`define WINDOW1_ADDR 7'h01

// Field positions inside the literal and offset operands.
`define PAGE_LIT_MSB 6
`define OFFSET_SIGN_BIT 5

// Pointer step for increment and decrement.
`define PTR_STEP 16'h0001

`endif

// [verilog/move_pkg.sv]
// Purpose: Types shared by the move execution logic and its pointer units.
// Assumes: Widths match the constants in move_defines.svh.
// Notes: Holds types only; numbers live in the defines header.
package move_pkg;

    // Instruction selector presented by the decoder.
    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_LOAD_PAGE_LATCH_LITERAL = 3'h1,
        OP_LOAD_ACCUMULATOR_LITERAL = 3'h2,
        OP_STORE_ACCUMULATOR_DIRECT = 3'h3,
        OP_STORE_ACCUMULATOR_INDIRECT = 3'h4
    } op_type;

    // Addressing mode field of the indirect store.
    typedef enum logic [1:0] {
        MODE_PRE_INC = 2'h0,
        MODE_PRE_DEC = 2'h1,
        MODE_POST_INC = 2'h2,
        MODE_POST_DEC = 2'h3
    } mode_type;

    // State of one pointer unit.
    typedef struct packed {
        logic [15:0] ptr;
    } ptr_state_type;

    // State of the execution block.
    typedef struct packed {
        logic [7:0] acc;
        logic [6:0] page;
        logic we;
        logic direct;
        logic [15:0] addr;
        logic [7:0] wdata;
    } exec_state_type;

endpackage

// [verilog/ptr_if.sv]
// Purpose: Carries update requests to a pointer unit and its addresses back.
// Assumes: One instance per pointer register.
// Notes: The effective address is combinational from the unit; ptr is the registered pointer value.
`timescale 1ns/1ps
`default_nettype none
interface ptr_if;
    import move_pkg::*;

    logic upd;
    logic rel;
    mode_type mode;
    logic [5:0] off;
    logic [15:0] ptr;
    logic [15:0] ea;

    modport ctrl (output upd, output rel, output mode, output off, input ptr, input ea);
    modport unit (input upd, input rel, input mode, input off, output ptr, output ea);
endinterface
`default_nettype wire

// [verilog/pointer_unit.sv]
// Purpose: One 16-bit indirect pointer register with its address arithmetic.
// Assumes: The controller raises upd for exactly the cycle of an indirect store.
// Notes: Arithmetic is modulo 2**16, so both ends wrap without extra logic.
`timescale 1ns/1ps
`default_nettype none
`include "move_defines.svh"
module pointer_unit (
    input wire logic clk,
    input wire logic rst_n,
    ptr_if.unit pif
);
    import move_pkg::*;

    ptr_state_type st_r;
    ptr_state_type st_nxt;
    logic [15:0] inc_val;
    logic [15:0] dec_val;
    logic [15:0] rel_val;

    // Both neighbours and the offset target are formed every cycle; truncation gives the wrap.
    assign inc_val = st_r.ptr + `PTR_STEP;
    assign dec_val = st_r.ptr - `PTR_STEP;
    assign rel_val = st_r.ptr + {{10{pif.off[`OFFSET_SIGN_BIT]}}, pif.off};
    assign pif.ptr = st_r.ptr;

    // Effective address and the value written back on an update.
    always_comb begin
        st_nxt = st_r;
        if (pif.rel) begin
            pif.ea = rel_val; // [RQ7]
        end else begin
            case (pif.mode)
                MODE_PRE_INC: pif.ea = inc_val; // [RQ5]
                MODE_PRE_DEC: pif.ea = dec_val; // [RQ5]
                MODE_POST_INC: pif.ea = st_r.ptr; // [RQ6]
                MODE_POST_DEC: pif.ea = st_r.ptr; // [RQ6]
                default: pif.ea = st_r.ptr;
            endcase
        end
        if (pif.upd && !pif.rel) begin
            case (pif.mode)
                MODE_PRE_INC, MODE_POST_INC: st_nxt.ptr = inc_val; // [RQ8]
                MODE_PRE_DEC, MODE_POST_DEC: st_nxt.ptr = dec_val; // [RQ8]
                default: st_nxt.ptr = st_r.ptr;
            endcase
        end
    end

    // The pointer lands on the same edge that takes the store.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= '{ptr: `PTR_RESET};
        end else begin
            st_r <= st_nxt; // [RQ10]
        end
    end
endmodule
`default_nettype wire

// [verilog/move_exec.sv]
// Purpose: Executes the literal loads and the direct and indirect accumulator stores.
// Assumes: The decoder presents one instruction per EXEC_VALID cycle; memory takes MEM_WE pulses.
// Notes: Store results appear on the memory port one cycle after the instruction is taken.
//
// Summary of operation
// RQ1 - Page literal goes to page latch, flags untouched.
// RQ2 - Byte literal loads accumulator, flags untouched.
// RQ3 - Direct store copies accumulator to file address.
// RQ4 - Indirect store writes accumulator through chosen pointer.
// RQ5 - Modes 00/01 adjust pointer, then store.
// RQ6 - Modes 10/11 store, then adjust pointer.
// RQ7 - Relative form adds signed offset, pointer unchanged.
// RQ8 - Pointers are 16-bit and wrap around.
// RQ9 - Window registers have no storage; redirect through pointer.
// RQ10 - Store and pointer update finish in one cycle.
`timescale 1ns/1ps
`default_nettype none
`include "move_defines.svh"
module move_exec #(
    parameter int PTR_W = 16,
    parameter int N_PTR = 2
) (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic EXEC_VALID,
    input wire move_pkg::op_type EXEC_OP,
    input wire logic [7:0] EXEC_LITERAL,
    input wire logic [6:0] EXEC_FILE_ADDR,
    input wire logic EXEC_PTR_SEL,
    input wire move_pkg::mode_type EXEC_ADDRESSING_MODE_FIELD,
    input wire logic EXEC_RELATIVE,
    input wire logic [5:0] EXEC_OFFSET,
    output logic [7:0] ACCUMULATOR,
    output logic [6:0] PROGRAM_COUNTER_HIGH_LATCH,
    output logic MEM_WE,
    output logic MEM_DIRECT,
    output logic [15:0] MEM_ADDR,
    output logic [7:0] MEM_WDATA,
    output logic [15:0] PTR0,
    output logic [15:0] PTR1
);
    import move_pkg::*;

    exec_state_type st_r;
    exec_state_type st_nxt;
    logic is_indirect;
    logic taken;

    // The pointer datapath and the window decode are built for exactly two 16-bit pointers.
    if (PTR_W != 16) begin : g_bad_width
        $error("Pointer width must be 16.");
    end
    if (N_PTR != 2) begin : g_bad_count
        $error("Exactly two pointer registers are supported.");
    end

    ptr_if pif [N_PTR] ();

    // An instruction only counts while reset is released, so checks never see a cleared cycle as executed.
    assign taken = RST_N && EXEC_VALID;
    assign is_indirect = taken && (EXEC_OP == OP_STORE_ACCUMULATOR_INDIRECT);

    // One pointer unit per pointer register; only the selected one sees the update request.
    for (genvar i = 0; i < N_PTR; i++) begin : g_ptr
        assign pif[i].upd = is_indirect && (EXEC_PTR_SEL == 1'(i)); // [RQ10]
        assign pif[i].rel = EXEC_RELATIVE;
        assign pif[i].mode = EXEC_ADDRESSING_MODE_FIELD;
        assign pif[i].off = EXEC_OFFSET;
        pointer_unit u_ptr (
            .clk(CORE_CLK),
            .rst_n(RST_N),
            .pif(pif[i])
        );
    end

    // Next state. The block holds no status flags, so none of these instructions can touch them.
    always_comb begin
        st_nxt = st_r;
        st_nxt.we = 1'b0;
        st_nxt.direct = 1'b0;
        if (EXEC_VALID) begin
            case (EXEC_OP)
                OP_LOAD_PAGE_LATCH_LITERAL: begin
                    st_nxt.page = EXEC_LITERAL[`PAGE_LIT_MSB:0]; // [RQ1]
                end
                OP_LOAD_ACCUMULATOR_LITERAL: begin
                    st_nxt.acc = EXEC_LITERAL; // [RQ2]
                end
                OP_STORE_ACCUMULATOR_DIRECT: begin
                    st_nxt.we = 1'b1;
                    st_nxt.wdata = st_r.acc;
                    // A window address is not a real register; it reaches the pointed location instead.
                    if (EXEC_FILE_ADDR == `WINDOW0_ADDR) begin
                        st_nxt.addr = pif[0].ptr; // [RQ9]
                    end else if (EXEC_FILE_ADDR == `WINDOW1_ADDR) begin
                        st_nxt.addr = pif[1].ptr; // [RQ9]
                    end else begin
                        st_nxt.direct = 1'b1;
                        st_nxt.addr = {9'h000, EXEC_FILE_ADDR}; // [RQ3]
                    end
                end
                OP_STORE_ACCUMULATOR_INDIRECT: begin
                    st_nxt.we = 1'b1;
                    st_nxt.wdata = st_r.acc; // [RQ4]
                    st_nxt.addr = EXEC_PTR_SEL ? pif[1].ea : pif[0].ea; // [RQ4]
                end
                default: begin
                    st_nxt.we = 1'b0;
                end
            endcase
        end
    end

    // Single state register; the memory strobe is a one-cycle pulse from it.
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            st_r <= '{acc: `ACC_RESET, page: `PAGE_RESET, we: 1'b0, direct: 1'b0,
                      addr: 16'h0000, wdata: 8'h00};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from flip-flops.
    assign ACCUMULATOR = st_r.acc;
    assign PROGRAM_COUNTER_HIGH_LATCH = st_r.page;
    assign MEM_WE = st_r.we;
    assign MEM_DIRECT = st_r.direct;
    assign MEM_ADDR = st_r.addr;
    assign MEM_WDATA = st_r.wdata;
    assign PTR0 = pif[0].ptr;
    assign PTR1 = pif[1].ptr;

    // Checks. They compare against values captured at the instruction edge.
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    property p_page_load;
        taken && EXEC_OP == OP_LOAD_PAGE_LATCH_LITERAL |=>
            PROGRAM_COUNTER_HIGH_LATCH == $past(EXEC_LITERAL[6:0]) && !MEM_WE;
    endproperty
    a_page_load: assert property (p_page_load) else $error("page latch not loaded"); // [RQ1]

    property p_acc_load;
        taken && EXEC_OP == OP_LOAD_ACCUMULATOR_LITERAL |=>
            ACCUMULATOR == $past(EXEC_LITERAL) && $stable(PTR0) && $stable(PTR1);
    endproperty
    a_acc_load: assert property (p_acc_load) else $error("accumulator not loaded"); // [RQ2]

    property p_direct;
        taken && EXEC_OP == OP_STORE_ACCUMULATOR_DIRECT && EXEC_FILE_ADDR > `WINDOW1_ADDR |=>
            MEM_WE && MEM_DIRECT && MEM_ADDR == {9'h000, $past(EXEC_FILE_ADDR)}
            && MEM_WDATA == $past(ACCUMULATOR);
    endproperty
    a_direct: assert property (p_direct) else $error("direct store wrong"); // [RQ3]

    property p_indirect_data;
        is_indirect |=> MEM_WE && !MEM_DIRECT && MEM_WDATA == $past(ACCUMULATOR);
    endproperty
    a_indirect_data: assert property (p_indirect_data) else $error("indirect store data wrong"); // [RQ4]

    property p_pre_inc;
        is_indirect && !EXEC_RELATIVE && !EXEC_PTR_SEL && EXEC_ADDRESSING_MODE_FIELD == MODE_PRE_INC |=>
            PTR0 == 16'($past(PTR0) + 16'h0001) && MEM_ADDR == PTR0;
    endproperty
    a_pre_inc: assert property (p_pre_inc) else $error("pre-increment wrong"); // [RQ5]

    property p_post_dec;
        is_indirect && !EXEC_RELATIVE && EXEC_PTR_SEL && EXEC_ADDRESSING_MODE_FIELD == MODE_POST_DEC |=>
            MEM_ADDR == $past(PTR1) && PTR1 == 16'($past(PTR1) - 16'h0001);
    endproperty
    a_post_dec: assert property (p_post_dec) else $error("post-decrement wrong"); // [RQ6]

    property p_relative;
        is_indirect && EXEC_RELATIVE && !EXEC_PTR_SEL |=>
            $stable(PTR0) && MEM_ADDR == 16'(PTR0 + {{10{$past(EXEC_OFFSET[5])}}, $past(EXEC_OFFSET)});
    endproperty
    a_relative: assert property (p_relative) else $error("relative store wrong"); // [RQ7]

    property p_wrap;
        is_indirect && !EXEC_RELATIVE && !EXEC_PTR_SEL && PTR0 == 16'h0000
            && EXEC_ADDRESSING_MODE_FIELD == MODE_PRE_DEC |=> PTR0 == 16'hffff && MEM_ADDR == 16'hffff;
    endproperty
    a_wrap: assert property (p_wrap) else $error("pointer did not wrap"); // [RQ8]

    property p_window;
        taken && EXEC_OP == OP_STORE_ACCUMULATOR_DIRECT && EXEC_FILE_ADDR == `WINDOW0_ADDR |=>
            MEM_WE && !MEM_DIRECT && MEM_ADDR == PTR0 && $stable(PTR0);
    endproperty
    a_window: assert property (p_window) else $error("window not redirected"); // [RQ9]

    property p_idle;
        RST_N && !is_indirect |=> $stable(PTR0) && $stable(PTR1);
    endproperty
    a_idle: assert property (p_idle) else $error("pointer moved without a store"); // [RQ10]

    property p_post_inc;
        is_indirect && !EXEC_RELATIVE && !EXEC_PTR_SEL && EXEC_ADDRESSING_MODE_FIELD == MODE_POST_INC |=>
            MEM_ADDR == $past(PTR0) && PTR0 == 16'($past(PTR0) + 16'h0001);
    endproperty
    a_post_inc: assert property (p_post_inc) else $error("post-increment wrong"); // [RQ6]

    property p_pre_dec;
        is_indirect && !EXEC_RELATIVE && EXEC_PTR_SEL && EXEC_ADDRESSING_MODE_FIELD == MODE_PRE_DEC |=>
            PTR1 == 16'($past(PTR1) - 16'h0001) && MEM_ADDR == PTR1;
    endproperty
    a_pre_dec: assert property (p_pre_dec) else $error("pre-decrement wrong"); // [RQ5]

    // The second pointer has its own adder, so the offset form is checked on it separately.
    property p_relative1;
        is_indirect && EXEC_RELATIVE && EXEC_PTR_SEL |=>
            $stable(PTR1) && MEM_ADDR == 16'(PTR1 + {{10{$past(EXEC_OFFSET[5])}}, $past(EXEC_OFFSET)});
    endproperty
    a_relative1: assert property (p_relative1) else $error("relative store through pointer 1 wrong"); // [RQ7]

    property p_window1;
        taken && EXEC_OP == OP_STORE_ACCUMULATOR_DIRECT && EXEC_FILE_ADDR == `WINDOW1_ADDR |=>
            MEM_WE && !MEM_DIRECT && MEM_ADDR == PTR1 && $stable(PTR1);
    endproperty
    a_window1: assert property (p_window1) else $error("window 1 not redirected"); // [RQ9]

    // Idle cycles and the unused codes must not write and must leave the accumulator and page latch alone.
    property p_quiet;
        RST_N && (!EXEC_VALID || EXEC_OP == OP_NONE || EXEC_OP > OP_STORE_ACCUMULATOR_INDIRECT) |=>
            !MEM_WE && $stable(ACCUMULATOR) && $stable(PROGRAM_COUNTER_HIGH_LATCH);
    endproperty
    a_quiet: assert property (p_quiet) else $error("state changed without an instruction"); // [RQ2]

    c_pre_inc: cover property (is_indirect && EXEC_ADDRESSING_MODE_FIELD == MODE_PRE_INC && !EXEC_RELATIVE);
    c_relative: cover property (is_indirect && EXEC_RELATIVE && EXEC_OFFSET[5]);
    c_window: cover property (EXEC_VALID && EXEC_OP == OP_STORE_ACCUMULATOR_DIRECT
                              && EXEC_FILE_ADDR == `WINDOW1_ADDR);
    c_back_to_back: cover property (is_indirect ##1 is_indirect);
endmodule
`default_nettype wire

// [test/data_file_model.sv]
// Purpose: Data memory file on the far side of the move logic, recording every write.
// Assumes: Writes arrive as one-cycle MEM_WE pulses sampled on the rising clock edge.
// Notes: Direct and linear spaces are kept apart by the top bit of the key.
`timescale 1ns/1ps
`default_nettype none
module data_file_model (
    input wire logic clk,
    input wire logic we,
    input wire logic direct,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata
);
    logic [7:0] mem [int];
    int writes = 0;

    // Each sampled pulse is one write, so a pulse held too long shows up as extra writes.
    always @(posedge clk) begin
        if (we === 1'b1) begin
            mem[{direct, addr}] = wdata;
            writes++;
        end
    end
endmodule
`default_nettype wire

// [test/testbench.sv]
// Purpose: Self-checking bench for the literal and indirect move logic.
// Assumes: One instruction per cycle, results visible one cycle after the instruction is taken.
// Notes: A reference model runs beside the design and is compared every cycle.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import move_pkg::*;
    logic CORE_CLK = 1'b0;
    logic RST_N = 1'b0;
    logic EXEC_VALID = 1'b0;
    op_type EXEC_OP = OP_NONE;
    logic [7:0] EXEC_LITERAL = 8'h00;
    logic [6:0] EXEC_FILE_ADDR = 7'h00;
    logic EXEC_PTR_SEL = 1'b0;
    mode_type EXEC_ADDRESSING_MODE_FIELD = MODE_PRE_INC;
    logic EXEC_RELATIVE = 1'b0;
    logic [5:0] EXEC_OFFSET = 6'h00;
    logic [7:0] ACCUMULATOR;
    logic [6:0] PROGRAM_COUNTER_HIGH_LATCH;
    logic MEM_WE;
    logic MEM_DIRECT;
    logic [15:0] MEM_ADDR;
    logic [7:0] MEM_WDATA;
    logic [15:0] PTR0;
    logic [15:0] PTR1;
    logic [7:0] m_acc = 8'h00;
    logic [6:0] m_page = 7'h00;
    logic [15:0] m_ptr [2] = '{16'h0000, 16'h0000};
    logic m_we = 1'b0;
    logic m_dir = 1'b0;
    logic [15:0] m_addr = 16'h0000;
    logic [7:0] m_wdata = 8'h00;
    logic check_on = 1'b0;
    int n_fail = 0;
    int compares = 0;
    int stores = 0;
    int seed = 32'h91727862;

    move_exec move_exec_inst (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .EXEC_VALID(EXEC_VALID), .EXEC_OP(EXEC_OP),
        .EXEC_LITERAL(EXEC_LITERAL), .EXEC_FILE_ADDR(EXEC_FILE_ADDR), .EXEC_PTR_SEL(EXEC_PTR_SEL),
        .EXEC_ADDRESSING_MODE_FIELD(EXEC_ADDRESSING_MODE_FIELD), .EXEC_RELATIVE(EXEC_RELATIVE),
        .EXEC_OFFSET(EXEC_OFFSET), .ACCUMULATOR(ACCUMULATOR), .PROGRAM_COUNTER_HIGH_LATCH(PROGRAM_COUNTER_HIGH_LATCH),
        .MEM_WE(MEM_WE), .MEM_DIRECT(MEM_DIRECT), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .PTR0(PTR0), .PTR1(PTR1));

    data_file_model data_file_model_inst (.clk(CORE_CLK), .we(MEM_WE), .direct(MEM_DIRECT), .addr(MEM_ADDR),
        .wdata(MEM_WDATA));

    // Free-running core clock at 100 MHz.
    initial begin
        forever #5 CORE_CLK = ~CORE_CLK;
    end

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Drives one instruction, checks the previous one, then advances the model.
    task automatic apply(input logic rst, input logic v, input logic [2:0] op, input logic [7:0] lit,
                         input logic [6:0] fa, input logic sel, input logic [1:0] md, input logic rel,
                         input logic [5:0] off);
        logic [15:0] p;
        @(posedge CORE_CLK);
        RST_N <= rst;
        EXEC_VALID <= v;
        EXEC_OP <= op_type'(op);
        EXEC_LITERAL <= lit;
        EXEC_FILE_ADDR <= fa;
        EXEC_PTR_SEL <= sel;
        EXEC_ADDRESSING_MODE_FIELD <= mode_type'(md);
        EXEC_RELATIVE <= rel;
        EXEC_OFFSET <= off;
        #1;
        if (check_on) begin
            chk("accumulator", m_acc, ACCUMULATOR);
            chk("page latch", m_page, PROGRAM_COUNTER_HIGH_LATCH);
            chk("pointer 0", m_ptr[0], PTR0);
            chk("pointer 1", m_ptr[1], PTR1);
            chk("write pulse", m_we, MEM_WE);
            chk("store address", m_addr, MEM_ADDR);
            chk("store data", m_wdata, MEM_WDATA);
            if (m_we) begin
                chk("direct flag", m_dir, MEM_DIRECT);
            end
        end
        check_on = 1'b1;
        // Pointer arithmetic in 16 bits wraps at both ends without special cases.
        m_we = 1'b0;
        p = m_ptr[sel];
        if (!rst) begin
            m_acc = 8'h00;
            m_page = 7'h00;
            m_ptr = '{16'h0000, 16'h0000};
            m_addr = 16'h0000;
            m_wdata = 8'h00;
        end else if (v) begin
            case (op)
                3'h1: m_page = lit[6:0];
                3'h2: m_acc = lit;
                3'h3: begin
                    m_we = 1'b1;
                    m_wdata = m_acc;
                    m_dir = fa > 7'h01;
                    m_addr = m_dir ? {9'h000, fa} : m_ptr[fa[0]];
                end
                3'h4: begin
                    m_we = 1'b1;
                    m_dir = 1'b0;
                    m_wdata = m_acc;
                    if (rel) begin
                        m_addr = p + {{10{off[5]}}, off};
                    end else begin
                        if (!md[1]) p = md[0] ? p - 16'h0001 : p + 16'h0001;
                        m_addr = p;
                        if (md[1]) p = md[0] ? p - 16'h0001 : p + 16'h0001;
                        m_ptr[sel] = p;
                    end
                end
                default: ;
            endcase
        end
        if (m_we) stores++;
    endtask

    // The run is long only if something hangs, so a hard limit counts as a mismatch.
    initial begin
        #900000;
        n_fail++;
        $display("FAIL run limit expected finish seen hang");
        print_verdict();
    end

    // Directed corner cases first, then random back-to-back traffic with a reset in the middle.
    initial begin
        logic [7:0] r;
        repeat (8) apply(1'b0, 1'b0, 3'h0, 8'h00, 7'h00, 1'b0, 2'h0, 1'b0, 6'h00);
        apply(1'b1, 1'b1, 3'h2, 8'h5a, 7'h00, 1'b0, 2'h0, 1'b0, 6'h00);
        apply(1'b1, 1'b1, 3'h4, 8'h00, 7'h00, 1'b0, 2'h1, 1'b0, 6'h00);
        apply(1'b1, 1'b1, 3'h4, 8'h00, 7'h00, 1'b0, 2'h2, 1'b0, 6'h00);
        apply(1'b1, 1'b1, 3'h4, 8'h00, 7'h00, 1'b1, 2'h3, 1'b0, 6'h00);
        apply(1'b1, 1'b1, 3'h4, 8'h00, 7'h00, 1'b1, 2'h0, 1'b0, 6'h00);
        apply(1'b1, 1'b1, 3'h4, 8'h00, 7'h00, 1'b0, 2'h0, 1'b1, 6'h20);
        apply(1'b1, 1'b1, 3'h4, 8'h00, 7'h00, 1'b1, 2'h1, 1'b1, 6'h1f);
        apply(1'b1, 1'b1, 3'h3, 8'h00, 7'h25, 1'b0, 2'h0, 1'b0, 6'h00);
        apply(1'b1, 1'b1, 3'h3, 8'h00, 7'h01, 1'b0, 2'h0, 1'b0, 6'h00);
        apply(1'b1, 1'b1, 3'h1, 8'hff, 7'h00, 1'b0, 2'h0, 1'b0, 6'h00);
        for (int i = 5; i < 8; i++) apply(1'b1, 1'b1, 3'(i), 8'h33, 7'h40, 1'b0, 2'h0, 1'b0, 6'h00);
        chk("file 25h", 16'h005a, 16'(data_file_model_inst.mem[{1'b1, 16'h0025}]));
        for (int i = 0; i < 600; i++) begin
            r = 8'($random(seed));
            apply(i != 300, r[7:1] != 0, 3'($random(seed)), 8'($random(seed)),
                  r[6:5] == 0 ? {6'h00, r[0]} : 7'($random(seed)), r[4], r[3:2], r[1] & r[5],
                  6'($random(seed)));
        end
        repeat (3) apply(1'b1, 1'b0, 3'h0, 8'h00, 7'h00, 1'b0, 2'h0, 1'b0, 6'h00);
        chk("write count", 16'(stores), 16'(data_file_model_inst.writes));
        print_verdict();
    end
endmodule
`default_nettype wire
